// >>> inc/dacpo_pkg.sv
`default_nettype none
// shared constants and types for the converter control block
package dacpo_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  // config register fields
  localparam int CFG_DCLK2_BIT = 0;
  localparam int CFG_DDR_BIT = 1;
  localparam int CFG_TRIM_DIS_BIT = 13;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TRIM_BIT = 1;
  localparam int ST_ADC_BIT = 2;
  localparam int ST_PDA_BIT = 3;
  localparam int ST_PDQ_BIT = 4;
  localparam int ST_EXT_BIT = 5;
  // pin vector positions
  localparam int IN_CAL = 0;
  localparam int IN_DLY = 1;
  localparam int IN_PD = 2;
  localparam int IN_PDQ = 3;
  localparam int IN_EDGE = 4;
  localparam int IN_LVL = 5;
  localparam int IN_EXT = 6;
  localparam int N_PINS = 7;
  // timing counts in input clock cycles
  localparam int T_CAL_L = 80;
  localparam int T_CAL_H = 80;
  localparam int SYNC_WAIT = 3;
  localparam int TRIM_CYC = 256;
  localparam int ADC_CYC = 1024;
  localparam int PIPE_LAT = 8;
  localparam int DLY_SHORT_CYC = 8192;
  localparam int DLY_LONG_CYC = 65536;
  localparam int CNT_W = 24;
  // calibration sequencer states
  typedef enum logic [4:0] {
    S_INIT = 5'h01,
    S_DELAY = 5'h02,
    S_IDLE = 5'h04,
    S_TRIM = 5'h08,
    S_ADC = 5'h10
  } dacpo_state_t;
  // one pair of demultiplexed output buses
  typedef struct packed {
    logic [7:0] bus_a;
    logic [7:0] bus_b;
  } dacpo_pair_t;
endpackage
`default_nettype wire

// >>> core/dacpo_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - calibrate at power-up and on command, busy high
// - output clock stops in calibration unless trim off
// - power-on calibration waits selected delay
// - calibrate pin high at power-up skips it
// - calibration starts high count after rise
// - command trims termination then converter, skippable
// - delay select picks one of two delays
// - delay counter halts while power-down held
// - extended mode always uses short delay
// - edge select picks data change edge
// - range pair may become second clock
// - level select picks drive strength
// - power-down all, or second channel only
// - powered-down channel outputs high impedance, flush
// - power-down waits for running calibration
// - command during power-down is dropped
// - alternate conversions onto two buses
// - double rate: word per edge, quarter clock
// - output codes are offset binary
// - extended select high means pin control only
module dacpo_ctrl #(
  parameter int DLY_SHORT = dacpo_pkg::DLY_SHORT_CYC,
  parameter int DLY_LONG = dacpo_pkg::DLY_LONG_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cal_pin,
  input wire logic cal_delay_select,
  input wire logic powerdown_all,
  input wire logic powerdown_second_channel,
  input wire logic output_edge_select,
  input wire logic output_level_select,
  input wire logic ext_ctrl_select,
  input wire logic [7:0] sample_i,
  input wire logic [7:0] sample_q,
  input wire logic sample_oor,
  output dacpo_pkg::dacpo_pair_t bus_i,
  output dacpo_pkg::dacpo_pair_t bus_q,
  output logic bus_i_oe,
  output logic bus_q_oe,
  output logic word_valid_i,
  output logic word_valid_q,
  output logic output_data_clock,
  output logic range_or_clock2,
  output logic drive_strong,
  output logic calibration_busy,
  output logic term_trim_active,
  output logic adc_cal_active
);

  // two-stage synchroniser for all pins
  logic [dacpo_pkg::N_PINS-1:0] meta_r;
  logic [dacpo_pkg::N_PINS-1:0] pin_r;
  wire [dacpo_pkg::N_PINS-1:0] pin_raw = {ext_ctrl_select, output_level_select,
    output_edge_select, powerdown_second_channel, powerdown_all, cal_delay_select, cal_pin};

  // pins only reach logic after the second stage
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      pin_r <= '0;
    end
    else
    begin
      meta_r <= pin_raw;
      pin_r <= meta_r;
    end
  end

  // synchronised pin levels
  wire cal_s = pin_r[dacpo_pkg::IN_CAL];
  wire dly_s = pin_r[dacpo_pkg::IN_DLY];
  wire pd_s = pin_r[dacpo_pkg::IN_PD];
  wire pdq_s = pin_r[dacpo_pkg::IN_PDQ];
  wire edge_s = pin_r[dacpo_pkg::IN_EDGE];
  wire lvl_s = pin_r[dacpo_pkg::IN_LVL];
  // pin high selects pin control only
  wire ext_mode = ~pin_r[dacpo_pkg::IN_EXT];

  // configuration register, effective only in extended mode
  logic [15:0] cfg_r;
  wire trim_dis = ext_mode & cfg_r[dacpo_pkg::CFG_TRIM_DIS_BIT];
  wire dclk2_en = ext_mode & cfg_r[dacpo_pkg::CFG_DCLK2_BIT];
  wire ddr_en = ext_mode & cfg_r[dacpo_pkg::CFG_DDR_BIT];

  // sequencer state and its counter
  dacpo_pkg::dacpo_state_t state_r;
  dacpo_pkg::dacpo_state_t state_nxt;
  logic [dacpo_pkg::CNT_W-1:0] cnt_r;
  logic [dacpo_pkg::CNT_W-1:0] cnt_nxt;
  wire st_init = (state_r == dacpo_pkg::S_INIT);
  wire st_delay = (state_r == dacpo_pkg::S_DELAY);
  wire st_idle = (state_r == dacpo_pkg::S_IDLE);
  wire st_trim = (state_r == dacpo_pkg::S_TRIM);
  wire st_adc = (state_r == dacpo_pkg::S_ADC);
  wire st_cal = st_trim | st_adc;

  // delay length: short in extended mode, else pin picks
  wire dly_long = ~ext_mode & dly_s;
  wire [dacpo_pkg::CNT_W-1:0] dly_lim = dly_long ?
    dacpo_pkg::CNT_W'(DLY_LONG - 1) : dacpo_pkg::CNT_W'(DLY_SHORT - 1);

  // power-down takes effect only outside calibration
  wire pd_all_act = pd_s & ~st_cal;
  wire pd_q_act = (pd_s | pdq_s) & ~st_cal;
  // device counts as powered down for command filtering
  wire powered_down = pd_s & ~st_cal;

  // calibrate pin filter: low count then high count
  logic [7:0] lo_cnt_r;
  logic [7:0] hi_cnt_r;
  logic lo_ok_r;
  logic cal_req_r;
  wire lo_done = (lo_cnt_r == 8'(dacpo_pkg::T_CAL_L - 1));
  wire hi_done = (hi_cnt_r == 8'(dacpo_pkg::T_CAL_H - 1));

  // command detector, cleared while powered down
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lo_cnt_r <= 8'h00;
      hi_cnt_r <= 8'h00;
      lo_ok_r <= 1'b0;
      cal_req_r <= 1'b0;
    end
    else if (powered_down)
    begin
      // nothing remembered across power-down
      lo_cnt_r <= 8'h00;
      hi_cnt_r <= 8'h00;
      lo_ok_r <= 1'b0;
      cal_req_r <= 1'b0;
    end
    else if (!cal_s)
    begin
      // count low time, saturating once valid
      hi_cnt_r <= 8'h00;
      cal_req_r <= 1'b0;
      if (!lo_done)
        lo_cnt_r <= lo_cnt_r + 8'h01;
      else
        lo_ok_r <= 1'b1;
    end
    else
    begin
      // high time after a valid low starts the command
      lo_cnt_r <= 8'h00;
      cal_req_r <= lo_ok_r & hi_done;
      if (lo_ok_r & hi_done)
      begin
        lo_ok_r <= 1'b0;
        hi_cnt_r <= 8'h00;
      end
      else if (lo_ok_r)
        hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + dacpo_pkg::CNT_W'(1);
    case (state_r)
      dacpo_pkg::S_INIT:
      begin
        // let pin synchronisers settle first
        if (cnt_r == dacpo_pkg::CNT_W'(dacpo_pkg::SYNC_WAIT - 1))
        begin
          cnt_nxt = '0;
          state_nxt = cal_s ? dacpo_pkg::S_IDLE : dacpo_pkg::S_DELAY;
        end
      end
      dacpo_pkg::S_DELAY:
      begin
        if (pd_s)
          cnt_nxt = cnt_r;
        else if (cnt_r >= dly_lim)
        begin
          cnt_nxt = '0;
          state_nxt = dacpo_pkg::S_TRIM;
        end
      end
      dacpo_pkg::S_IDLE:
      begin
        cnt_nxt = '0;
        if (cal_req_r)
          state_nxt = trim_dis ? dacpo_pkg::S_ADC : dacpo_pkg::S_TRIM;
      end
      dacpo_pkg::S_TRIM:
      begin
        // termination trim, then converter calibration
        if (cnt_r == dacpo_pkg::CNT_W'(dacpo_pkg::TRIM_CYC - 1))
        begin
          cnt_nxt = '0;
          state_nxt = dacpo_pkg::S_ADC;
        end
      end
      dacpo_pkg::S_ADC:
      begin
        if (cnt_r == dacpo_pkg::CNT_W'(dacpo_pkg::ADC_CYC - 1))
        begin
          cnt_nxt = '0;
          state_nxt = dacpo_pkg::S_IDLE;
        end
      end
      default:
      begin
        cnt_nxt = '0;
        state_nxt = dacpo_pkg::S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= dacpo_pkg::S_INIT;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // offset binary coding of core samples
  wire [7:0] code_i = {~sample_i[7], sample_i[6:0]};
  wire [7:0] code_q = {~sample_q[7], sample_q[6:0]};

  // demux phase: odd cycle completes a pair
  logic ph_r;
  logic [7:0] hold_i_r;
  logic [7:0] hold_q_r;
  logic hold_or_r;
  logic or_word_r;

  // clock stops during calibration unless trim is off
  wire output_data_clock_stop = st_cal & ~trim_dis;
  wire output_data_clock_sdr = ph_r ? edge_s : ~edge_s;
  wire output_data_clock_ddr = ph_r ? ~output_data_clock : output_data_clock;
  wire output_data_clock_nxt = output_data_clock_stop ? 1'b0 : (ddr_en ? output_data_clock_ddr : output_data_clock_sdr);
  wire or_nxt = ph_r ? (hold_or_r | sample_oor) : or_word_r;

  // demux and output clock generation
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_r <= 1'b0;
      hold_i_r <= 8'h00;
      hold_q_r <= 8'h00;
      hold_or_r <= 1'b0;
      or_word_r <= 1'b0;
      bus_i <= '0;
      bus_q <= '0;
      output_data_clock <= 1'b0;
      range_or_clock2 <= 1'b0;
    end
    else
    begin
      ph_r <= ~ph_r;
      output_data_clock <= output_data_clock_nxt;
      // range pair doubles as second clock
      range_or_clock2 <= dclk2_en ? output_data_clock_nxt : or_nxt;
      or_word_r <= or_nxt;
      if (!ph_r)
      begin
        // even conversion waits for its partner
        hold_i_r <= code_i;
        hold_q_r <= code_q;
        hold_or_r <= sample_oor;
      end
      else
      begin
        // both buses update together at half rate
        bus_i <= '{bus_a: hold_i_r, bus_b: code_i};
        bus_q <= '{bus_a: hold_q_r, bus_b: code_q};
      end
    end
  end

  // output enables and pipeline refill tracking
  logic [3:0] lat_i_r;
  logic [3:0] lat_q_r;
  wire lat_i_full = (lat_i_r == 4'(dacpo_pkg::PIPE_LAT));
  wire lat_q_full = (lat_q_r == 4'(dacpo_pkg::PIPE_LAT));

  // channel power-down and word validity
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_i_oe <= 1'b0;
      bus_q_oe <= 1'b0;
      lat_i_r <= 4'h0;
      lat_q_r <= 4'h0;
      word_valid_i <= 1'b0;
      word_valid_q <= 1'b0;
    end
    else
    begin
      bus_i_oe <= ~pd_all_act;
      bus_q_oe <= ~pd_q_act;
      // stale words flushed before marking valid
      if (pd_all_act)
        lat_i_r <= 4'h0;
      else if (!lat_i_full)
        lat_i_r <= lat_i_r + 4'h1;
      if (pd_q_act)
        lat_q_r <= 4'h0;
      else if (!lat_q_full)
        lat_q_r <= lat_q_r + 4'h1;
      word_valid_i <= lat_i_full & ~pd_all_act;
      word_valid_q <= lat_q_full & ~pd_q_act;
    end
  end

  // status flags and drive level
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      calibration_busy <= 1'b0;
      term_trim_active <= 1'b0;
      adc_cal_active <= 1'b0;
      drive_strong <= 1'b0;
    end
    else
    begin
      calibration_busy <= st_cal;
      term_trim_active <= st_trim;
      adc_cal_active <= st_adc;
      drive_strong <= lvl_s;
    end
  end

  // register decode
  wire sel_cfg = (reg_addr == dacpo_pkg::REG_CFG);
  wire sel_stat = (reg_addr == dacpo_pkg::REG_STAT);
  wire cfg_we = reg_wr & sel_cfg & ext_mode;
  wire [15:0] stat_val = 16'(st_cal) << dacpo_pkg::ST_BUSY_BIT
    | 16'(st_trim) << dacpo_pkg::ST_TRIM_BIT
    | 16'(st_adc) << dacpo_pkg::ST_ADC_BIT
    | 16'(pd_all_act) << dacpo_pkg::ST_PDA_BIT
    | 16'(pd_q_act) << dacpo_pkg::ST_PDQ_BIT
    | 16'(ext_mode) << dacpo_pkg::ST_EXT_BIT;
  wire [15:0] rd_val = sel_cfg ? cfg_r : (sel_stat ? stat_val : 16'h0000);

  // register writes and one-cycle read data
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_r <= dacpo_pkg::CFG_RST;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (cfg_we)
        cfg_r <= reg_wdata;
      reg_rdata <= reg_rd ? rd_val : 16'h0000;
    end
  end

  // checks on the sequencer and outputs
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_busy_follows_cal: assert property (st_cal |=> calibration_busy)
    else $error("busy low during calibration");
  a_output_data_clock_held_low: assert property ((st_cal && !trim_dis) [*2] |-> !output_data_clock)
    else $error("output clock ran during calibration");
  a_skip_poweron: assert property (st_init && cal_s
    && cnt_r == dacpo_pkg::CNT_W'(dacpo_pkg::SYNC_WAIT - 1) |=> st_idle)
    else $error("power-on calibration not skipped");
  a_cmd_starts_cal: assert property (st_idle && cal_req_r |=> st_cal ##1 calibration_busy)
    else $error("command did not start calibration");
  a_delay_frozen: assert property (st_delay && pd_s |=> $stable(cnt_r))
    else $error("delay counted during power-down");
  a_ext_short_delay: assert property (st_delay && ext_mode && !pd_s
    && cnt_r == dacpo_pkg::CNT_W'(DLY_SHORT - 1) |=> st_trim)
    else $error("long delay used in extended mode");
  a_pd_hiz: assert property (st_idle && pd_s [*2] |-> !bus_i_oe && !bus_q_oe)
    else $error("outputs driven while powered down");
  a_pd_waits_cal: assert property (st_cal |=> bus_i_oe && bus_q_oe)
    else $error("power-down entered mid calibration");
  a_pd_drops_cmd: assert property (powered_down |=> !cal_req_r)
    else $error("command kept during power-down");
  a_flush_wait: assert property ($fell(pd_all_act) |-> !word_valid_i [*4])
    else $error("word marked valid too early");

endmodule
`default_nettype wire

// >>> core/_unused_placeholder_never.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> tb/dacpo_rx.sv
`timescale 1ns/100ps
`default_nettype none
// receiving logic on the far side, clocked by the sample clock
module dacpo_rx (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic output_data_clock,
  input wire dacpo_pkg::dacpo_pair_t bus_i,
  input wire logic word_valid_i,
  input wire logic calibration_busy,
  output logic [15:0] output_data_clock_edges,
  output logic rise_chg,
  output logic [15:0] cal_done,
  output logic [7:0] last_a
);
  logic output_data_clock_q; // previous output clock level
  logic busy_q; // previous busy level
  dacpo_pkg::dacpo_pair_t bus_q; // previous bus words
  // edge finder and word capture
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      output_data_clock_edges <= 16'h0000;
      rise_chg <= 1'b0;
      cal_done <= 16'h0000;
      last_a <= 8'h00;
      output_data_clock_q <= 1'b0;
      busy_q <= 1'b0;
      bus_q <= '0;
    end
    else
    begin
      output_data_clock_q <= output_data_clock;
      busy_q <= calibration_busy;
      bus_q <= bus_i;
      if (output_data_clock != output_data_clock_q)
        output_data_clock_edges <= output_data_clock_edges + 16'h0001;
      // did data move on this rising clock edge
      if (output_data_clock && !output_data_clock_q)
        rise_chg <= (bus_i != bus_q);
      // completion taken from busy, not from a fixed wait
      if (busy_q && !calibration_busy)
        cal_done <= cal_done + 16'h0001;
      // stale words after power-down are dropped
      if (word_valid_i)
        last_a <= bus_i.bus_a;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_dual_adc_cal_powerdown_output_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the converter control block
module test_dual_adc_cal_powerdown_output_ctrl;
  localparam int DS = 20; // short power-on delay
  localparam int DL = 40; // long power-on delay
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic cal_pin = 1'b0;
  logic cal_delay_select = 1'b1;
  logic powerdown_all = 1'b0;
  logic powerdown_second_channel = 1'b0;
  logic output_edge_select = 1'b1;
  logic output_level_select = 1'b0;
  logic ext_ctrl_select = 1'b0;
  logic [7:0] sample_i = 8'h00;
  logic [7:0] sample_q = 8'h00;
  logic ramp = 1'b0;
  dacpo_pkg::dacpo_pair_t bus_i;
  dacpo_pkg::dacpo_pair_t bus_q;
  logic bus_i_oe;
  logic bus_q_oe;
  logic word_valid_i;
  logic output_data_clock;
  logic range_or_clock2;
  logic drive_strong;
  logic calibration_busy;
  logic term_trim_active;
  logic adc_cal_active;
  logic [15:0] output_data_clock_edges;
  logic rise_chg;
  logic word_valid_q; // q channel word validity
  logic [15:0] cal_done; // completions seen by the receiver
  logic [7:0] last_a; // last word kept by the receiver
  int mismatches = 0;
  int total_checks = 0;
  // block under test with shortened delays
  dacpo_ctrl #(.DLY_SHORT(DS), .DLY_LONG(DL)) dacpo_ctrl_inst (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cal_pin(cal_pin), .cal_delay_select(cal_delay_select), .powerdown_all(powerdown_all),
    .powerdown_second_channel(powerdown_second_channel), .output_edge_select(output_edge_select),
    .output_level_select(output_level_select), .ext_ctrl_select(ext_ctrl_select), .sample_i(sample_i),
    .sample_q(sample_q), .sample_oor(1'b0), .bus_i(bus_i), .bus_q(bus_q), .bus_i_oe(bus_i_oe),
    .bus_q_oe(bus_q_oe), .word_valid_i(word_valid_i), .word_valid_q(word_valid_q),
    .output_data_clock(output_data_clock),
    .range_or_clock2(range_or_clock2), .drive_strong(drive_strong), .calibration_busy(calibration_busy),
    .term_trim_active(term_trim_active), .adc_cal_active(adc_cal_active));
  // far-side receiver
  dacpo_rx dacpo_rx_inst (.core_clk(core_clk), .resetn(resetn), .output_data_clock(output_data_clock),
    .bus_i(bus_i), .word_valid_i(word_valid_i), .calibration_busy(calibration_busy),
    .output_data_clock_edges(output_data_clock_edges), .rise_chg(rise_chg), .cal_done(cal_done), .last_a(last_a));
  // 50 MHz sample clock
  always #10 core_clk = ~core_clk;
  // ramp on both converters
  always @(posedge core_clk)
    if (ramp)
    begin
      sample_i <= sample_i + 8'h01;
      sample_q <= sample_q - 8'h01;
    end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // count falling edges until busy reaches v, bounded
  task automatic wait_busy(input logic v, input int lim, output int n);
    n = 0;
    while (calibration_busy !== v && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    cyc(12);
    resetn <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // low then high on the calibrate pin, n = wait for busy
  task automatic cal_cmd(output int n);
    @(posedge core_clk);
    cal_pin <= 1'b0;
    cyc(dacpo_pkg::T_CAL_L + 4);
    cal_pin <= 1'b1;
    wait_busy(1'b1, 200, n);
  endtask
  // follow one calibration from its first busy cycle
  task automatic cal_watch(input logic trim);
    int n;
    logic [15:0] e0;
    logic [15:0] c0;
    @(negedge core_clk);
    e0 = output_data_clock_edges;
    c0 = cal_done;
    check(16'({term_trim_active, adc_cal_active}), 16'({trim, !trim}));
    wait_busy(1'b0, 2000, n);
    check(16'(n + 1), 16'(trim ? dacpo_pkg::TRIM_CYC + dacpo_pkg::ADC_CYC : dacpo_pkg::ADC_CYC));
    check(16'(output_data_clock_edges == e0), 16'(trim));
    // receiver sees the busy fall one edge later
    @(negedge core_clk);
    check(cal_done, c0 + 16'h0001);
  endtask
  // power-on calibration in extended mode uses the short delay
  task automatic t_poweron;
    int n;
    wait_busy(1'b1, 200, n);
    check(16'(n >= DS && n <= DS + 10), 16'h0001);
    cal_watch(1'b1);
  endtask
  // commanded calibration, with and without trim
  task automatic t_cal;
    int n;
    logic [15:0] d;
    logic [15:0] w;
    for (int t = 0; t < 2; t++)
    begin
      w = t ? 16'h2000 : 16'h0000;
      wr(dacpo_pkg::REG_CFG, w);
      rd(dacpo_pkg::REG_CFG, d);
      check(d, w);
      // host recalibrates only after power-on calibration is over
      cal_cmd(n);
      check(16'(n >= dacpo_pkg::T_CAL_H && n <= dacpo_pkg::T_CAL_H + 8), 16'h0001);
      cal_watch(t == 0);
    end
    rd(4'hf, d);
    check(d, 16'h0000);
    rd(dacpo_pkg::REG_STAT, d);
    check(16'(d[dacpo_pkg::ST_EXT_BIT]), 16'h0001);
    // a low phase too short is no command
    @(posedge core_clk);
    cal_pin <= 1'b0;
    cyc(40);
    cal_pin <= 1'b1;
    wait_busy(1'b1, 150, n);
    check(16'(n), 16'h0096);
  endtask
  // coding, demux, edge, level, second clock, double rate
  task automatic t_stream;
    logic [7:0] sv [3];
    logic [7:0] df;
    logic p;
    int hh;
    sv = '{8'h7f, 8'h80, 8'h00};
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk);
      sample_i <= sv[k];
      cyc(6);
      @(negedge core_clk);
      check({bus_i.bus_a, bus_i.bus_b}, {2{sv[k] ^ 8'h80}});
    end
    @(posedge core_clk);
    ramp <= 1'b1;
    cyc(6);
    @(negedge core_clk);
    df = bus_i.bus_b - bus_i.bus_a;
    check(16'(df), 16'h0001);
    df = bus_q.bus_a - bus_q.bus_b;
    check(16'(df), 16'h0001);
    for (int e = 1; e >= 0; e--)
    begin
      @(posedge core_clk);
      output_edge_select <= e[0];
      output_level_select <= e[0];
      cyc(8);
      @(negedge core_clk);
      check(16'(rise_chg), 16'(e));
      check(16'(drive_strong), 16'(e));
    end
    for (int m = 0; m < 2; m++)
    begin
      wr(dacpo_pkg::REG_CFG, m ? 16'h0003 : 16'h0001);
      cyc(4);
      hh = 0;
      p = 1'b0;
      repeat (8)
      begin
        @(negedge core_clk);
        check(16'(range_or_clock2), 16'(output_data_clock));
        hh += int'(p & output_data_clock);
        p = output_data_clock;
      end
      check(16'(hh != 0), 16'(m));
    end
    wr(dacpo_pkg::REG_CFG, 16'h0000);
  endtask
  // power-down around and after a calibration
  task automatic t_pd;
    int n;
    logic [7:0] la;
    cal_cmd(n);
    @(posedge core_clk);
    powerdown_all <= 1'b1;
    cyc(10);
    @(negedge core_clk);
    check(16'(bus_i_oe), 16'h0001);
    wait_busy(1'b0, 2000, n);
    cyc(6);
    @(negedge core_clk);
    check(16'({bus_i_oe, bus_q_oe, word_valid_i}), 16'h0000);
    la = last_a;
    cal_cmd(n);
    check(16'(n), 16'h00c8);
    @(posedge core_clk);
    powerdown_all <= 1'b0;
    cyc(5);
    @(negedge core_clk);
    check(16'({bus_i_oe, word_valid_i}), 16'h0002);
    check(16'(last_a), 16'(la));
    cyc(10);
    @(negedge core_clk);
    check(16'(word_valid_i), 16'h0001);
    wait_busy(1'b1, 120, n);
    check(16'(n), 16'h0078);
    @(posedge core_clk);
    powerdown_second_channel <= 1'b1;
    cyc(6);
    @(negedge core_clk);
    check(16'({bus_i_oe, bus_q_oe, word_valid_i, word_valid_q}), 16'h000a);
    @(posedge core_clk);
    powerdown_second_channel <= 1'b0;
  endtask
  // pin-controlled mode and pin levels at reset
  task automatic t_pins;
    int n;
    logic [15:0] d;
    ext_ctrl_select <= 1'b1;
    cal_pin <= 1'b0;
    do_reset();
    wait_busy(1'b1, 200, n);
    check(16'(n >= DL && n <= DL + 10), 16'h0001);
    wr(dacpo_pkg::REG_CFG, 16'h2000);
    rd(dacpo_pkg::REG_CFG, d);
    check(d, 16'h0000);
    @(posedge core_clk);
    powerdown_all <= 1'b1;
    do_reset();
    wait_busy(1'b1, 80, n);
    check(16'(n), 16'h0050);
    @(posedge core_clk);
    powerdown_all <= 1'b0;
    wait_busy(1'b1, 200, n);
    check(16'(n >= DL && n <= DL + 12), 16'h0001);
    @(posedge core_clk);
    cal_pin <= 1'b1;
    do_reset();
    wait_busy(1'b1, 150, n);
    check(16'(n), 16'h0096);
    cal_cmd(n);
    check(16'(n >= dacpo_pkg::T_CAL_H && n <= dacpo_pkg::T_CAL_H + 8), 16'h0001);
  endtask
  // main sequence
  initial
  begin
    do_reset();
    t_poweron();
    t_cal();
    t_stream();
    t_pd();
    t_pins();
    end_sim();
  end
  // hang guard, about four and a half times the expected run
  initial
  begin
    cyc(30000);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
